// file: src/tvp_pkg.sv
// Constants, register map and pattern codes of the test video pattern generator.
package tvp_pkg;

	// ------------------------------------------------------------
	// Clock and line timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int LINE_NTSC_NS = 63556;
	localparam int LINE_PAL_NS = 64000;
	localparam int HSYNC_NS = 4700;
	localparam int ACT_START_NS = 10700;
	localparam int ACT_LEN_NS = 52000;
	localparam int LINE_NTSC_CYC = LINE_NTSC_NS * CLK_MHZ / 1000;
	localparam int LINE_PAL_CYC = LINE_PAL_NS * CLK_MHZ / 1000;
	localparam int HSYNC_CYC = (HSYNC_NS * CLK_MHZ + 999) / 1000;
	localparam int ACT_START_CYC = (ACT_START_NS * CLK_MHZ + 999) / 1000;
	localparam int ACT_LEN_CYC = ACT_LEN_NS * CLK_MHZ / 1000;

	// ------------------------------------------------------------
	// Field timing in lines, pixel size and counter widths
	// ------------------------------------------------------------
	localparam int FIELD_NTSC_LINES = 262;
	localparam int FIELD_PAL_LINES = 312;
	localparam int VSYNC_LINES = 3;
	localparam int VBLANK_LINES = 20;
	localparam int PIX_SHIFT = 4;
	localparam int HCNT_W = 14;
	localparam int LINE_W = 10;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam int CTRL_IDX = 12'hFE6;
	localparam int STAT_IDX = 12'hFE7;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(CTRL_IDX * 4);
	localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'(STAT_IDX * 4);
	localparam int BIT_EN = 7;
	localparam int BIT_VBLK = 6;
	localparam int BIT_STD = 5;
	localparam int BIT_INV = 4;
	localparam int BIT_SRC = 3;
	localparam int PAT_LSB = 8;
	localparam int PAT_W = 3;
	localparam logic [7:0] CTRL_WMASK = 8'hF8;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Pattern codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PAT_BLACK = 3'b000,
		PAT_WHITE = 3'b001,
		PAT_HATCH = 3'b010,
		PAT_DOT = 3'b011,
		PAT_BAR = 3'b100,
		PAT_UPPER = 3'b101,
		PAT_HSIG = 3'b110,
		PAT_HRES = 3'b111
	} pattern_e;

endpackage

// file: src/test_video_pattern_output.sv
// Test video pattern generator with a three-state video pin and an AXI4-Lite control port.
//
// What this block does
// - Video pin is high, low or released.
// - Composite sync drives the pin low.
// - Black and pedestal release the pin.
// - White pattern areas drive the pin high.
// - Eight patterns, each optionally inverted.
// - One control register holds all configuration.
// - Reset clears control: disabled, pattern zero.
//
// Decided for this implementation: the AXI4-Lite slave port.
module test_video_pattern_output
	import tvp_pkg::*;
#(
	parameter int LINE_NTSC = LINE_NTSC_CYC,
	parameter int LINE_PAL = LINE_PAL_CYC,
	parameter int HSYNC = HSYNC_CYC,
	parameter int ACT_START = ACT_START_CYC,
	parameter int ACT_LEN = ACT_LEN_CYC,
	parameter int NTSC_LINES = FIELD_NTSC_LINES,
	parameter int PAL_LINES = FIELD_PAL_LINES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sync inputs from the port pins, active low
	input wire logic port_hsync_n,
	input wire logic port_vsync_n,
	// Three-state video pin
	output logic video_o,
	output logic video_oe,
	// Selected display sync towards the on-screen display, active low
	output logic osd_hsync_n,
	output logic osd_vsync_n
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (HSYNC < 1 || HSYNC >= ACT_START || ACT_START + ACT_LEN > LINE_NTSC
			|| LINE_NTSC > LINE_PAL || LINE_PAL >= (1 << HCNT_W)) begin : g_chk_h
		$error("Line timing parameters out of range.");
	end
	if (NTSC_LINES <= VBLANK_LINES || PAL_LINES >= (1 << LINE_W)
			|| NTSC_LINES > PAL_LINES) begin : g_chk_v
		$error("Field timing parameters out of range.");
	end

	// ------------------------------------------------------------
	// Sized timing constants
	// ------------------------------------------------------------
	localparam logic [HCNT_W-1:0] H_NTSC_LAST = HCNT_W'(LINE_NTSC - 1);
	localparam logic [HCNT_W-1:0] H_PAL_LAST = HCNT_W'(LINE_PAL - 1);
	localparam logic [HCNT_W-1:0] H_SYNC = HCNT_W'(HSYNC);
	localparam logic [HCNT_W-1:0] H_VS_NTSC = HCNT_W'(LINE_NTSC - HSYNC);
	localparam logic [HCNT_W-1:0] H_VS_PAL = HCNT_W'(LINE_PAL - HSYNC);
	localparam logic [HCNT_W-1:0] H_ACT0 = HCNT_W'(ACT_START);
	localparam logic [HCNT_W-1:0] H_ACT1 = HCNT_W'(ACT_START + ACT_LEN);
	localparam logic [LINE_W-1:0] L_NTSC_LAST = LINE_W'(NTSC_LINES - 1);
	localparam logic [LINE_W-1:0] L_PAL_LAST = LINE_W'(PAL_LINES - 1);
	localparam logic [LINE_W-1:0] L_VSYNC = LINE_W'(VSYNC_LINES);
	localparam logic [LINE_W-1:0] L_VBLANK = LINE_W'(VBLANK_LINES);
	localparam logic [LINE_W-1:0] Y_HALF_NTSC = LINE_W'((NTSC_LINES - VBLANK_LINES) / 2);
	localparam logic [LINE_W-1:0] Y_HALF_PAL = LINE_W'((PAL_LINES - VBLANK_LINES) / 2);
	localparam logic [LINE_W-1:0] X_MID = LINE_W'((ACT_LEN >> PIX_SHIFT) / 2);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic aw_have_r, aw_have_nxt;
	logic w_have_r, w_have_nxt;
	logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	pattern_e pat_r, pat_nxt;
	logic [1:0] sync1_r, sync2_r, sync3_r;
	logic [1:0] stab_r, stab_nxt;
	logic [HCNT_W-1:0] hcnt_r, hcnt_nxt;
	logic [LINE_W-1:0] line_r, line_nxt;
	logic video_r, video_nxt;
	logic oe_r, oe_nxt;
	logic osd_h_r, osd_h_nxt;
	logic osd_v_r, osd_v_nxt;

	// ------------------------------------------------------------
	// Decoded timing
	// ------------------------------------------------------------
	logic en, vblk_sup, pal, inv, pseudo;
	logic [HCNT_W-1:0] h_last, h_vs, hoff;
	logic [LINE_W-1:0] l_last, y_half, x, y;
	logic h_fall, v_fall, h_end;
	logic in_vsync, in_vblank, csync, act_h, pat_white, white;

	assign en = ctrl_r[BIT_EN];
	assign vblk_sup = ctrl_r[BIT_VBLK];
	assign pal = ctrl_r[BIT_STD];
	assign inv = ctrl_r[BIT_INV];
	assign pseudo = ctrl_r[BIT_SRC];

	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign video_o = video_r;
	assign video_oe = oe_r;
	assign osd_hsync_n = osd_h_r;
	assign osd_vsync_n = osd_v_r;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		aw_addr_nxt = aw_addr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		ctrl_nxt = ctrl_r;
		pat_nxt = pat_r;

		// Write address and data are latched separately, in either order.
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_have_r && w_have_r) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_SLVERR;
			if ({aw_addr_r[ADDR_W-1:2], 2'h0} == CTRL_ADDR) begin
				bresp_nxt = RESP_OKAY;
				// Bits two to zero have no storage, so stray ones do no harm.
				if (wstrb_r[0]) begin
					ctrl_nxt = wdata_r[7:0] & CTRL_WMASK;
				end
				if (wstrb_r[1]) begin
					pat_nxt = pattern_e'(wdata_r[PAT_LSB +: PAT_W]);
				end
			end
		end

		// The control word is write only; status shows the scan position.
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			if ({s_axi_araddr[ADDR_W-1:2], 2'h0} == STAT_ADDR) begin
				rdata_nxt = {6'h00, line_r, 2'h0, hcnt_r};
			end else if ({s_axi_araddr[ADDR_W-1:2], 2'h0} != CTRL_ADDR) begin
				rresp_nxt = RESP_SLVERR;
			end
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_comb begin
		// A pin level counts once the second and third stages agree.
		stab_nxt = stab_r;
		for (int i = 0; i < 2; i++) begin
			if (sync2_r[i] == sync3_r[i]) begin
				stab_nxt[i] = sync3_r[i];
			end
		end
		h_fall = stab_r[0] && !stab_nxt[0];
		v_fall = stab_r[1] && !stab_nxt[1];

		// Counts assume the system clock rate fixed at build time.
		h_last = pal ? H_PAL_LAST : H_NTSC_LAST;
		h_vs = pal ? H_VS_PAL : H_VS_NTSC;
		l_last = pal ? L_PAL_LAST : L_NTSC_LAST;
		y_half = pal ? Y_HALF_PAL : Y_HALF_NTSC;

		// In port mode the pins restart the line and field.
		// A count already past a shorter line after a standard switch must still wrap.
		h_end = (hcnt_r >= h_last) || (!pseudo && h_fall);
		hcnt_nxt = h_end ? '0 : hcnt_r + 1'b1;
		line_nxt = line_r;
		if (h_end) begin
			line_nxt = (line_r >= l_last) ? '0 : line_r + 1'b1;
		end
		if (!pseudo && v_fall) begin
			line_nxt = '0;
		end
		if (!en) begin
			hcnt_nxt = '0;
			line_nxt = '0;
		end

		// Vertical sync lines are serrated: low for all but a sync width.
		in_vsync = line_r < L_VSYNC;
		in_vblank = line_r < L_VBLANK;
		csync = in_vsync ? (hcnt_r < h_vs) : (hcnt_r < H_SYNC);
		act_h = (hcnt_r >= H_ACT0) && (hcnt_r < H_ACT1);
		hoff = hcnt_r - H_ACT0;
		x = LINE_W'(hoff >> PIX_SHIFT);
		y = line_r - L_VBLANK;

		case (pat_r)
			PAT_BLACK: pat_white = 1'b0;
			PAT_WHITE: pat_white = 1'b1;
			PAT_HATCH: pat_white = (x[4:0] == 5'h00) || (y[4:0] == 5'h00);
			PAT_DOT: pat_white = (x[4:0] == 5'h00) && (y[4:0] == 5'h00);
			PAT_BAR: pat_white = ((x >> 2) == (X_MID >> 2)) || ((y >> 2) == (y_half >> 2));
			PAT_UPPER: pat_white = y < y_half;
			PAT_HSIG: pat_white = x[5];
			PAT_HRES: pat_white = x[0];
			default: pat_white = 1'b0;
		endcase

		// Inversion swaps white and black inside the picture area only.
		white = act_h && !(in_vblank && vblk_sup) && (pat_white ^ inv);

		// Sync wins over picture; anything else leaves the divider at black.
		video_nxt = en && !csync && white;
		oe_nxt = en && (csync || white);

		osd_h_nxt = pseudo ? !(en && hcnt_r < H_SYNC) : stab_r[0];
		osd_v_nxt = pseudo ? !(en && in_vsync) : stab_r[1];
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			ctrl_r <= CTRL_RESET;
			pat_r <= PAT_BLACK;
			sync1_r <= 2'h3;
			sync2_r <= 2'h3;
			sync3_r <= 2'h3;
			stab_r <= 2'h3;
			hcnt_r <= '0;
			line_r <= '0;
			video_r <= 1'b0;
			oe_r <= 1'b0;
			osd_h_r <= 1'b1;
			osd_v_r <= 1'b1;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			ctrl_r <= ctrl_nxt;
			pat_r <= pat_nxt;
			sync1_r <= {port_vsync_n, port_hsync_n};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			stab_r <= stab_nxt;
			hcnt_r <= hcnt_nxt;
			line_r <= line_nxt;
			video_r <= video_nxt;
			oe_r <= oe_nxt;
			osd_h_r <= osd_h_nxt;
			osd_v_r <= osd_v_nxt;
		end
	end

endmodule

// file: sim/tvp_checker.sv
// Port checks for the test video generator.
module tvp_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Video pin
	input wire logic video_o,
	input wire logic video_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	wire sync = video_oe && !video_o;
	wire white = video_oe && video_o;
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence sync_run;
		sync [*8];
	endsequence
	write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		both_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
	b_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	r_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	busy_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("taken while busy");
	sync_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(sync) |-> sync_run) else $error("sync pulse short");
	white_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(white) |-> !$past(video_oe)) else $error("white not from black");
	reset_clear_a: assert property (@(posedge aclk)
		!aresetn |=> !video_oe && !s_axi_bvalid) else $error("reset left pin driven");
endmodule

// file: sim/video_divider.sv
// Resistor divider that turns the three-state pin into a screen level.
module video_divider (
	// Pin from the generator
	input wire logic video_o,
	input wire logic video_oe,
	// Level: 0 sync, 1 black, 2 white, 3 unknown pin
	output logic [1:0] level
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released pin is pulled to black, so the generator must never leave it unknown.
	always_comb begin
		if (video_oe === 1'b0) level = 2'h1;
		else if (video_oe !== 1'b1) level = 2'h3;
		else if (video_o === 1'b1) level = 2'h2;
		else if (video_o === 1'b0) level = 2'h0;
		else level = 2'h3;
	end
endmodule

// file: sim/test_video_pattern_output_test.sv
// Self-checking bench for the test video pattern generator.
module test_video_pattern_output_test import tvp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LN = 200, LP = 220, HS = 10, AL = 128, FN = 22, FP = 24;
	logic aclk = 0, aresetn = 0, port_hsync_n = 1, port_vsync_n = 1;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, level;
	logic video_o, video_oe, osd_hsync_n, osd_vsync_n;
	int bad_count = 0, checks_done = 0, cycles = 0, seed = 35798;

	test_video_pattern_output #(.LINE_NTSC(LN), .LINE_PAL(LP), .HSYNC(HS), .ACT_START(40),
		.ACT_LEN(AL), .NTSC_LINES(FN), .PAL_LINES(FP)) uut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_hsync_n,
		.port_vsync_n, .video_o, .video_oe, .osd_hsync_n, .osd_vsync_n);
	video_divider div (.video_o, .video_oe, .level);

	initial forever #4 aclk = ~aclk;

	task end_of_test;
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// A hung handshake would stall the run forever, so the cycle count caps it.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			bad_count++;
			end_of_test;
		end
	end

	task chk_bus(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task chk_cnt(input string n, input int e, input int g);
		checks_done++;
		if (g != e) begin
			bad_count++;
			$display("BAD %s exp %0d got %0d", n, e, g);
		end
	endtask

	function automatic int exp_white(input bit pal, input bit vb);
		return ((pal ? FP : FN) - (vb ? VBLANK_LINES : VSYNC_LINES)) * AL;
	endfunction
	function automatic int exp_sync(input bit pal);
		return ((pal ? FP : FN) - VSYNC_LINES) * HS + VSYNC_LINES * ((pal ? LP : LN) - HS);
	endfunction

	task automatic bus_wr(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awprot <= 3'($random(seed));
		s_axi_wstrb <= {2'($random(seed)), 2'h3};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1'($random(seed));
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1;
		end
		r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask
	task automatic bus_rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arprot <= 3'($random(seed));
		s_axi_arvalid <= 1;
		s_axi_rready <= 1'($random(seed));
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask

	task automatic measure(input int n, output int s, output int w, output int z);
		s = 0;
		w = 0;
		z = 0;
		repeat (n) begin
			@(posedge aclk);
			if (level === 2'h0) s++;
			else if (level === 2'h2) w++;
			else if (level === 2'h1) z++;
		end
	endtask
	// Counting over one whole field makes the totals independent of where it starts.
	task automatic run_cfg(input bit pal, vb, inv, input logic [2:0] p, output int w);
		int s, z, n;
		logic [1:0] r;
		n = pal ? FP * LP : FN * LN;
		bus_wr(CTRL_ADDR, {21'h0, p, 1'b1, vb, pal, inv, 4'h8}, r);
		chk_bus("wresp", 32'(RESP_OKAY), 32'(r));
		repeat (250) @(posedge aclk);
		measure(n, s, w, z);
		chk_cnt("sync", exp_sync(pal), s);
		chk_cnt("levels", n, s + w + z);
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int w0, w1, s, z;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		bus_rd(CTRL_ADDR, d, r);
		chk_bus("ctrl", 32'h0, d);
		bus_rd(STAT_ADDR, d, r);
		chk_bus("status idle", 32'h0, d);
		measure(400, s, w0, z);
		chk_cnt("idle", 400, z);
		bus_rd({4'h1, 8'($random(seed)), 2'h0}, d, r);
		chk_bus("unmapped", 32'(RESP_SLVERR), 32'(r));
		bus_wr(STAT_ADDR, 32'h0, r);
		chk_bus("ro write", 32'(RESP_SLVERR), 32'(r));
		for (int p = 0; p < 8; p++) begin
			run_cfg(0, 0, 0, 3'(p), w0);
			run_cfg(0, 0, 1, 3'(p), w1);
			chk_cnt("inv sum", exp_white(0, 0), w0 + w1);
			if (p < 2) chk_cnt("plain", p * exp_white(0, 0), w0);
			if (p == 5) chk_cnt("upper", (FN - VBLANK_LINES) / 2 * AL, w0);
			if (p == 7) chk_cnt("hres", exp_white(0, 0), 2 * w0);
		end
		run_cfg(1, 0, 0, 3'h1, w0);
		chk_cnt("pal", exp_white(1, 0), w0);
		run_cfg(0, 1, 0, 3'h1, w0);
		chk_cnt("vblank", exp_white(0, 1), w0);
		// Port mode: both pins fall together, which restarts the line and the field.
		bus_wr(CTRL_ADDR, 32'h0000_0180, r);
		chk_bus("port wresp", 32'(RESP_OKAY), 32'(r));
		repeat (3) @(posedge aclk);
		port_hsync_n <= 0;
		port_vsync_n <= 0;
		repeat (8) @(posedge aclk);
		chk_bus("osd sync", 32'h0, {30'h0, osd_vsync_n, osd_hsync_n});
		bus_rd(STAT_ADDR, d, r);
		chk_cnt("port line", 0, int'(d[25:16]));
		chk_cnt("port restart", 1, int'(d[13:0] < 40));
		port_hsync_n <= 1;
		port_vsync_n <= 1;
		repeat (8) @(posedge aclk);
		chk_bus("osd idle", 32'h3, {30'h0, osd_vsync_n, osd_hsync_n});
		end_of_test;
	end
endmodule

bind test_video_pattern_output tvp_checker chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .video_o, .video_oe);
